// [hw/pss_cfg.svh]
// constants of the protection switch sequencer: offsets, fields, timings
// assumes a single 25 MHz clock; times are given in microseconds
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// ****************************************************************
// clock and intervals
// ****************************************************************
`define PSS_CLK_MHZ 25
`define PSS_DEBOUNCE_US 2000
`define PSS_RECOVER_INT_US 500
`define PSS_RECOVER_EXT_US 100
`define PSS_STARTUP_INIT_US 24000
`define PSS_STARTUP_TIMEOUT_US 48000
`define PSS_BLANK_US 24000
`define PSS_RETRY_US 720000

// ****************************************************************
// register map
// ****************************************************************
`define PSS_ADDR_CONFIG 12'h000
`define PSS_ADDR_STATUS 12'h004
`define PSS_CFG_EXT_BIT 0
`define PSS_CFG_HOLD_BIT 1
`define PSS_CFG_RESET 2'h1
`define PSS_ST_STATE_LSB 0
`define PSS_ST_MODE_LSB 8
`define PSS_ST_FLAG_BIT 10
`define PSS_ST_CURRENT_SET_SENSE_BIT 11
`define PSS_ST_INT_BIT 12
`define PSS_ST_EXT_BIT 13
`define PSS_ST_THERM_BIT 14
`define PSS_DATA_ZERO 32'h0000_0000

`endif

// [hw/pss_enable_watch.sv]
// decodes the two enable inputs and reports any toggle of either one
// assumes enables already synchronous to the clock
`default_nettype none

module pss_enable_watch (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // enable inputs
    input wire logic highVoltageEnableN,
    input wire logic lowVoltageEnable,
    // decoded
    output logic enableOn,
    output logic enableToggled
);
    import pss_pkg::*;

    logic hvPrev_q;
    logic lvPrev_q;

    // ****************************************************************
    // previous levels
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            hvPrev_q <= 1'b1;
            lvPrev_q <= 1'b0;
        end
        else if (ce)
        begin
            hvPrev_q <= highVoltageEnableN;
            lvPrev_q <= lowVoltageEnable;
        end
    end

    // off only for high-voltage enable 1 with low-voltage enable 0
    assign enableOn = !(highVoltageEnableN && !lowVoltageEnable);
    assign enableToggled = (hvPrev_q != highVoltageEnableN) ||
                           (lvPrev_q != lowVoltageEnable);

endmodule : pss_enable_watch

`default_nettype wire

// [hw/pss_interval_timer.sv]
// interval counter: restarts on request, counts while running
// assumes one clock with clock enable and synchronous reset
`default_nettype none

module pss_interval_timer (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // control
    input wire logic restart,
    input wire logic run,
    input wire pss_pkg::pss_count_t limit,
    // result
    output logic done,
    output pss_pkg::pss_count_t count
);
    import pss_pkg::*;

    pss_count_t count_q;

    // ****************************************************************
    // counter
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
            count_q <= 32'h0000_0000;
        else if (ce)
        begin
            if (restart)
                count_q <= 32'h0000_0000;
            else if (run && count_q != limit)
                count_q <= count_q + 32'h0000_0001;
        end
    end

    assign done = (count_q == limit);
    assign count = count_q;

endmodule : pss_interval_timer

`default_nettype wire

// [hw/pss_pkg.sv]
// types of the protection switch sequencer
// assumes pss_cfg.svh for all numeric constants
`default_nettype none

package pss_pkg;

    // ****************************************************************
    // sequencer states, one-hot
    // ****************************************************************
    typedef enum logic [7:0] {
        PSS_OFF        = 8'h01,
        PSS_DEBOUNCE   = 8'h02,
        PSS_RECOV_INT  = 8'h04,
        PSS_RECOV_EXT  = 8'h08,
        PSS_STARTUP    = 8'h10,
        PSS_ON         = 8'h20,
        PSS_RETRY      = 8'h40,
        PSS_LATCHED    = 8'h80
    } pss_state_e;

    // overcurrent behaviour, coded as the selector comparators report it
    typedef enum logic [1:0] {
        PSS_MODE_RETRY = 2'h0,
        PSS_MODE_LATCH = 2'h1,
        PSS_MODE_CONT  = 2'h2
    } pss_mode_e;

    typedef logic [31:0] pss_count_t;

    // synchronous comparator results
    typedef struct packed {
        logic uvAdjAboveSel;
        logic uvBelowInt;
        logic uvBelowExt;
        logic ovAdjAboveSel;
        logic ovAboveInt;
        logic ovAboveExt;
        logic outBelowUvLevel;
        logic dropAboveFlag;
        logic thermalShutdown;
        logic thermalFoldback;
        logic atCurrentLimit;
        logic severeOverload;
        logic currentSetOpen;
        logic currentSetLow;
        logic [1:0] limitBehaviourSelect;
    } pss_sense_s;

endpackage : pss_pkg

`default_nettype wire

// [hw/pss_sequencer.sv]
// protection switch sequencer top: gates, fault flag, apb registers
// assumes comparator inputs synchronous to the 25 MHz clock
//
// What this block does
// - off only when hvEnN=1 and lvEn=0
// - undervoltage threshold selected by adjust input
// - undervoltage holds internal switch off, flag asserted
// - overvoltage threshold selected by adjust input
// - overvoltage turns switch off, flag asserted
// - lockout clears: debounce, internal, external, flag released
// - turn on only after full debounce
// - skip debounce after lockout if output high
// - enable-caused turn-on always debounces
// - enable toggle clears short-circuit latch
// - startup interval limits current continuously
// - thermal foldback forces thermal power regulation
// - output not charged by timeout: latch off
// - startup timeout also after lockout restart
// - open current-set input blocks all current
// - first exit checks current-set resistor
// - mode sampled only after successful startup
// - ground retry, open continuous, resistor latch
// - severe overload turns both switches off
// - severe overload recovers within recovery delay
// - persisting overload handled per selected mode
// - autoretry: blanking, reset on clear, retry wait
// - latch-off: stay off after blanking expires
// - flag low for drop, thermal, resistor, lockout
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "pss_cfg.svh"
`default_nettype none

module pss_sequencer #(
    parameter int unsigned DebounceCycles =
        `PSS_DEBOUNCE_US * `PSS_CLK_MHZ,
    parameter int unsigned RecoverIntCycles =
        `PSS_RECOVER_INT_US * `PSS_CLK_MHZ,
    parameter int unsigned RecoverExtCycles =
        `PSS_RECOVER_EXT_US * `PSS_CLK_MHZ,
    parameter int unsigned StartupInitCycles =
        `PSS_STARTUP_INIT_US * `PSS_CLK_MHZ,
    parameter int unsigned StartupTimeoutCycles =
        `PSS_STARTUP_TIMEOUT_US * `PSS_CLK_MHZ,
    parameter int unsigned BlankCycles = `PSS_BLANK_US * `PSS_CLK_MHZ,
    parameter int unsigned RetryCycles = `PSS_RETRY_US * `PSS_CLK_MHZ
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic srst,
    input wire logic ce,
    // supervisor enables
    input wire logic highVoltageEnableN,
    input wire logic lowVoltageEnable,
    // comparator results
    input wire pss_pkg::pss_sense_s sense,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // switch control
    output logic intGateOn,
    output logic extGateOn,
    output logic currentBlocked,
    output logic limitContinuous,
    output logic thermalRegulate,
    output logic uvExtSelected,
    output logic ovExtSelected,
    // open-drain fault flag
    output logic faultFlagOut,
    output logic faultFlagOe
);
    import pss_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    pss_state_e state_q;
    pss_state_e state_d;
    pss_mode_e mode_q;
    logic [1:0] config_q;
    logic setiChecked_q;
    logic setiFault_q;
    logic fromLockout_q;
    logic intGate_q;
    logic extGate_q;
    logic flagOe_q;
    logic currentBlocked_q;
    logic limitCont_q;
    logic thermReg_q;
    logic uvExt_q;
    logic ovExt_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic enableOn;
    logic enableToggled;
    logic uvFault;
    logic ovFault;
    logic inputFault;
    logic stateDone;
    logic blankDone;
    logic blankRun;
    logic goOff;
    pss_count_t stateLimit;
    pss_count_t stateCount;

    function automatic logic addrMapped(input logic [11:0] a);
        addrMapped = (a == `PSS_ADDR_CONFIG) || (a == `PSS_ADDR_STATUS);
    endfunction : addrMapped

    // ****************************************************************
    // enables and lockout
    // ****************************************************************
    pss_enable_watch u_enable (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .highVoltageEnableN(highVoltageEnableN),
        .lowVoltageEnable(lowVoltageEnable),
        .enableOn(enableOn),
        .enableToggled(enableToggled)
    );

    // threshold choice by adjust input level
    assign uvFault = sense.uvAdjAboveSel ? sense.uvBelowExt :
                     sense.uvBelowInt;
    assign ovFault = sense.ovAdjAboveSel ? sense.ovAboveExt :
                     sense.ovAboveInt;
    assign inputFault = uvFault || ovFault;
    assign goOff = inputFault || !enableOn ||
                   config_q[`PSS_CFG_HOLD_BIT];

    // ****************************************************************
    // interval timers
    // ****************************************************************
    always_comb
    begin
        case (state_q)
            PSS_DEBOUNCE: stateLimit = pss_count_t'(DebounceCycles);
            PSS_RECOV_INT: stateLimit = pss_count_t'(RecoverIntCycles);
            PSS_RECOV_EXT: stateLimit = pss_count_t'(RecoverExtCycles);
            PSS_STARTUP: stateLimit = pss_count_t'(StartupTimeoutCycles);
            PSS_RETRY: stateLimit = pss_count_t'(RetryCycles);
            default: stateLimit = 32'h0000_0000;
        endcase
    end

    pss_interval_timer u_stateTimer (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .restart(state_d != state_q),
        .run(1'b1),
        .limit(stateLimit),
        .done(stateDone),
        .count(stateCount)
    );

    // blanking runs only at the limit and outside foldback
    assign blankRun = (state_q == PSS_ON) && sense.atCurrentLimit &&
                      !sense.thermalFoldback && mode_q != PSS_MODE_CONT;

    pss_interval_timer u_blankTimer (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .restart(!blankRun),
        .run(blankRun),
        .limit(pss_count_t'(BlankCycles)),
        .done(blankDone),
        .count()
    );

    // ****************************************************************
    // state machine
    // ****************************************************************
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            PSS_OFF:
                if (!goOff && !sense.thermalShutdown &&
                    !(setiChecked_q ? setiFault_q : sense.currentSetLow))
                begin
                    if (fromLockout_q && !sense.outBelowUvLevel)
                        state_d = PSS_RECOV_INT;
                    else
                        state_d = PSS_DEBOUNCE;
                end
            PSS_DEBOUNCE:
                if (goOff)
                    state_d = PSS_OFF;
                else if (stateDone)
                    state_d = PSS_RECOV_INT;
            PSS_RECOV_INT:
                if (goOff)
                    state_d = PSS_OFF;
                else if (stateDone)
                    state_d = PSS_RECOV_EXT;
            PSS_RECOV_EXT:
                if (goOff)
                    state_d = PSS_OFF;
                else if (sense.severeOverload)
                    state_d = PSS_RECOV_INT;
                else if (stateDone)
                    state_d = PSS_STARTUP;
            PSS_STARTUP:
                if (goOff)
                    state_d = PSS_OFF;
                else if (sense.severeOverload)
                    state_d = PSS_RECOV_INT;
                else if (stateDone)
                    state_d = sense.dropAboveFlag ? PSS_LATCHED
                                                  : PSS_ON;
            PSS_ON:
                if (goOff)
                    state_d = PSS_OFF;
                else if (sense.severeOverload)
                    state_d = PSS_RECOV_INT;
                else if (sense.thermalShutdown)
                    state_d = (mode_q == PSS_MODE_LATCH) ? PSS_LATCHED
                                                         : PSS_OFF;
                else if (blankDone && blankRun)
                    state_d = (mode_q == PSS_MODE_LATCH) ? PSS_LATCHED
                                                 : PSS_RETRY;
            PSS_RETRY:
                if (goOff)
                    state_d = PSS_OFF;
                else if (stateDone)
                    state_d = PSS_RECOV_INT;
            PSS_LATCHED:
                if (enableToggled || uvFault)
                    state_d = PSS_OFF;
            default:
                state_d = PSS_OFF;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            state_q <= PSS_OFF;
        else if (ce)
            state_q <= state_d;
    end

    // ****************************************************************
    // mode, resistor check, lockout memory
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
            mode_q <= PSS_MODE_CONT;
        else if (ce && state_q == PSS_STARTUP && state_d == PSS_ON)
        begin
            case (sense.limitBehaviourSelect)
                2'h0: mode_q <= PSS_MODE_RETRY;
                2'h1: mode_q <= PSS_MODE_LATCH;
                default: mode_q <= PSS_MODE_CONT;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            setiChecked_q <= 1'b0;
            setiFault_q <= 1'b0;
        end
        else if (ce && !setiChecked_q && state_q == PSS_OFF &&
                 !goOff && !sense.thermalShutdown)
        begin
            setiChecked_q <= 1'b1;
            setiFault_q <= sense.currentSetLow;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            fromLockout_q <= 1'b0;
        else if (ce)
        begin
            if (inputFault)
                fromLockout_q <= 1'b1;
            else if (enableToggled || state_d == PSS_STARTUP)
                fromLockout_q <= 1'b0;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            intGate_q <= 1'b0;
            extGate_q <= 1'b0;
            flagOe_q <= 1'b0;
            currentBlocked_q <= 1'b1;
            limitCont_q <= 1'b1;
            thermReg_q <= 1'b0;
            uvExt_q <= 1'b0;
            ovExt_q <= 1'b0;
        end
        else if (ce)
        begin
            intGate_q <= (state_d == PSS_RECOV_EXT ||
                          state_d == PSS_STARTUP || state_d == PSS_ON) &&
                         !sense.severeOverload && !inputFault;
            extGate_q <= (state_d == PSS_STARTUP || state_d == PSS_ON) &&
                         config_q[`PSS_CFG_EXT_BIT] &&
                         !sense.severeOverload && !inputFault;
            flagOe_q <= sense.dropAboveFlag || sense.thermalShutdown ||
                        setiFault_q || inputFault ||
                        (fromLockout_q && state_d != PSS_STARTUP &&
                         state_d != PSS_ON);
            currentBlocked_q <= sense.currentSetOpen;
            limitCont_q <= (state_d == PSS_STARTUP) ||
                           (mode_q == PSS_MODE_CONT);
            thermReg_q <= sense.thermalFoldback && intGate_q;
            uvExt_q <= sense.uvAdjAboveSel;
            ovExt_q <= sense.ovAdjAboveSel;
        end
    end

    assign intGateOn = intGate_q;
    assign extGateOn = extGate_q;
    assign faultFlagOe = flagOe_q;
    assign faultFlagOut = 1'b0;
    assign currentBlocked = currentBlocked_q;
    assign limitContinuous = limitCont_q;
    assign thermalRegulate = thermReg_q;
    assign uvExtSelected = uvExt_q;
    assign ovExtSelected = ovExt_q;

    // ****************************************************************
    // apb slave, one wait state
    // ****************************************************************
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `PSS_DATA_ZERO;
        end
        else if (ce)
        begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q)
            begin
                pslverr_q <= !addrMapped(paddr);
                prdata_q <= `PSS_DATA_ZERO;
                if (!pwrite && paddr == `PSS_ADDR_CONFIG)
                    prdata_q[1:0] <= config_q;
                else if (!pwrite && paddr == `PSS_ADDR_STATUS)
                begin
                    prdata_q[`PSS_ST_STATE_LSB +: 8] <= state_q;
                    prdata_q[`PSS_ST_MODE_LSB +: 2] <= mode_q;
                    prdata_q[`PSS_ST_FLAG_BIT] <= flagOe_q;
                    prdata_q[`PSS_ST_CURRENT_SET_SENSE_BIT] <= setiFault_q;
                    prdata_q[`PSS_ST_INT_BIT] <= intGate_q;
                    prdata_q[`PSS_ST_EXT_BIT] <= extGate_q;
                    prdata_q[`PSS_ST_THERM_BIT] <= thermReg_q;
                end
            end
            else
            begin
                pslverr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            config_q <= `PSS_CFG_RESET;
        else if (ce && psel && penable && pready_q && pwrite &&
                 paddr == `PSS_ADDR_CONFIG)
            config_q <= pwdata[1:0];
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst || !ce);

    chk_enable_off: assert property (
        !enableOn |=> !intGate_q && !extGate_q)
        else $error("switch on while enables request off");
    chk_uv_holds: assert property (
        uvFault |=> !intGate_q && flagOe_q)
        else $error("undervoltage did not hold switch off");
    chk_ov_select: assert property (
        sense.ovAdjAboveSel && sense.ovAboveExt |=> !intGate_q ##0 flagOe_q)
        else $error("adjustable overvoltage not honoured");
    chk_severe_off: assert property (
        sense.severeOverload |=> !intGate_q && !extGate_q)
        else $error("severe overload left a switch on");
    chk_ext_follows: assert property (
        extGate_q |-> intGate_q)
        else $error("external gate on without internal gate");
    chk_open_current_set_sense: assert property (
        sense.currentSetOpen |=> currentBlocked_q)
        else $error("open current-set input did not block current");
    chk_debounce_off: assert property (
        state_q == PSS_DEBOUNCE && goOff |=> state_q == PSS_OFF ##1
        !intGate_q)
        else $error("debounce did not abort on fault");
    chk_latch_holds: assert property (
        state_q == PSS_LATCHED && !enableToggled && !uvFault
        |=> state_q == PSS_LATCHED && !intGate_q)
        else $error("latched state left without toggle");
    chk_startup_cont: assert property (
        state_q == PSS_STARTUP |-> limitCont_q)
        else $error("startup not continuously limited");
    chk_current_set_sense_flag: assert property (
        setiFault_q |=> flagOe_q && !intGate_q)
        else $error("resistor fault not flagged");

    cov_reach_on: cover property (state_q == PSS_STARTUP ##1
        state_q == PSS_ON);
    cov_retry: cover property (state_q == PSS_ON ##1 state_q == PSS_RETRY);
    cov_latch: cover property (state_q == PSS_LATCHED ##1
        state_q == PSS_OFF);
    cov_severe: cover property (state_q == PSS_ON && sense.severeOverload
        ##1 state_q == PSS_RECOV_INT);

endmodule : pss_sequencer

`default_nettype wire

// [tb/pss_sequencer_test.sv]
// bench: sequencer with supervisor model, random comparator selects
// assumes short interval parameters and one 25 MHz clock
`default_nettype none

module pss_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // signals
    // ****************
    logic clock = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [1:0] cmd = 2'h0, mode;
    logic pready, pslverr, intGateOn, extGateOn, currentBlocked, err;
    logic limitContinuous, thermalRegulate, uvExtSelected, ovExtSelected;
    logic faultFlagOut, faultFlagOe, highVoltageEnableN, lowVoltageEnable;
    logic faultSeen;
    pss_pkg::pss_sense_s sense = 16'h0002;
    int failures = 0, check_count = 0, n;

    pss_sequencer #(.DebounceCycles(4), .RecoverIntCycles(3),
        .RecoverExtCycles(2), .StartupInitCycles(3),
        .StartupTimeoutCycles(8), .BlankCycles(5), .RetryCycles(6))
    i_pss_sequencer (.clock, .srst, .ce, .highVoltageEnableN,
        .lowVoltageEnable, .sense, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .intGateOn, .extGateOn,
        .currentBlocked, .limitContinuous, .thermalRegulate,
        .uvExtSelected, .ovExtSelected, .faultFlagOut, .faultFlagOe);

    pss_supervisor_model i_pss_supervisor_model (.clock, .cmd,
        .faultFlagOut, .faultFlagOe, .highVoltageEnableN,
        .lowVoltageEnable, .faultSeen);

    // ****************
    // tasks and tests
    // ****************
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do
            @(posedge clock);
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic waitGate(logic exp);
        n = 0;
        while (intGateOn !== exp && n < 60)
        begin
            @(posedge clock);
            n++;
        end
    endtask : waitGate

    task automatic final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    initial
    begin
        forever #20 clock = !clock;
    end

    initial
    begin
        #40000;
        failures++;
        final_report();
    end

    initial
    begin
        void'($urandom(19));
        repeat (3) @(posedge clock);
        srst <= 1'h0;
        mode = 2'($urandom_range(2));
        sense.limitBehaviourSelect <= mode;
        sense.uvAdjAboveSel <= 1'($urandom);
        sense.ovAdjAboveSel <= 1'($urandom);
        apb(1'h1, 12'h000, 32'h0000_0003);
        apb(1'h0, 12'h000, 32'h0000_0000);
        chk("config", 32'h0000_0003, rd);
        apb(1'h1, 12'h000, 32'h0000_0001);
        apb(1'h0, 12'h008, 32'h0000_0000);
        chk("slverr", 1'h1, err);
        apb(1'h0, 12'h004, 32'h0000_0000);
        chk("state", 8'h01, rd[7:0]);
        chk("uv select", sense.uvAdjAboveSel, uvExtSelected);
        chk("ov select", sense.ovAdjAboveSel, ovExtSelected);
        cmd <= 2'h1;
        waitGate(1'h1);
        chk("debounced", 1'h1, n > 7);
        repeat (4) @(posedge clock);
        chk("ext gate", 1'h1, extGateOn);
        chk("flag free", 1'h0, faultSeen);
        chk("startup", 1'h1, limitContinuous);
        repeat (12) @(posedge clock);
        apb(1'h0, 12'h004, 32'h0000_0000);
        chk("mode", mode, rd[9:8]);
        for (int c = 3; c >= 0; c--)
        begin
            cmd <= 2'(c);
            repeat (3) @(posedge clock);
            waitGate(c != 0);
            chk("enable", c != 0, intGateOn);
        end
        cmd <= 2'h2;
        repeat (2) @(posedge clock);
        sense.uvBelowExt <= sense.uvAdjAboveSel;
        sense.uvBelowInt <= !sense.uvAdjAboveSel;
        repeat (20) @(posedge clock);
        chk("uv gate", 1'h0, intGateOn);
        chk("uv flag", 1'h1, faultSeen);
        {sense.uvBelowExt, sense.uvBelowInt, sense.outBelowUvLevel} <= 3'h1;
        waitGate(1'h1);
        chk("uv debounce", 1'h1, n > 7);
        sense.outBelowUvLevel <= 1'h0;
        repeat (16) @(posedge clock);
        sense.ovAboveExt <= sense.ovAdjAboveSel;
        sense.ovAboveInt <= !sense.ovAdjAboveSel;
        repeat (2) @(posedge clock);
        chk("ov gate", 1'h0, extGateOn);
        chk("ov flag", 1'h1, faultSeen);
        {sense.ovAboveExt, sense.ovAboveInt} <= 2'h0;
        waitGate(1'h1);
        chk("no debounce", 1'h1, n < 8);
        repeat (16) @(posedge clock);
        sense.severeOverload <= 1'h1;
        repeat (2) @(posedge clock);
        chk("overload", 1'h0, intGateOn | extGateOn);
        sense.severeOverload <= 1'h0;
        waitGate(1'h1);
        chk("recovery", 1'h1, n < 7);
        repeat (16) @(posedge clock);
        cmd <= 2'h0;
        sense.dropAboveFlag <= 1'h1;
        repeat (2) @(posedge clock);
        cmd <= 2'h3;
        repeat (14) @(posedge clock);
        chk("drop flag", 1'h1, faultSeen);
        repeat (14) @(posedge clock);
        chk("timeout", 1'h0, intGateOn);
        sense.dropAboveFlag <= 1'h0;
        cmd <= 2'h0;
        @(posedge clock);
        cmd <= 2'h3;
        waitGate(1'h1);
        chk("toggle", 1'h1, intGateOn);
        repeat (16) @(posedge clock);
        {sense.thermalFoldback, sense.currentSetOpen} <= 2'h3;
        repeat (2) @(posedge clock);
        chk("foldback", 1'h1, thermalRegulate);
        chk("open set", 1'h1, currentBlocked);
        {ce, sense.thermalFoldback, sense.currentSetOpen} <= 3'h0;
        repeat (2) @(posedge clock);
        chk("freeze", 1'h1, currentBlocked);
        ce <= 1'h1;
        sense.atCurrentLimit <= 1'h1;
        repeat (9) @(posedge clock);
        chk("limit mode", mode == 2'h2, intGateOn);
        {sense.currentSetLow, srst} <= 2'h3;
        repeat (3) @(posedge clock);
        srst <= 1'h0;
        repeat (4) @(posedge clock);
        chk("current_set_sense", 2'h2, {faultSeen, intGateOn});
        final_report();
    end
endmodule : pss_sequencer_test

`default_nettype wire

// [tb/pss_supervisor_model.sv]
// supervisor model: drives both enables, reads the fault flag wire
// assumes a pull-up on the open-drain flag and one bench clock
`default_nettype none

module pss_supervisor_model (
    // clock
    input wire logic clock,
    // bench request: 0 off, 1 to 3 the three on codes
    input wire logic [1:0] cmd,
    // flag pins of the device
    input wire logic faultFlagOut,
    input wire logic faultFlagOe,
    // enables and flag as the supervisor sees it
    output logic highVoltageEnableN = 1'h1,
    output logic lowVoltageEnable = 1'h0,
    output logic faultSeen
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // enables and flag
    // ****************
    // released flag is pulled high, so no fault is seen
    assign faultSeen = faultFlagOe ? !faultFlagOut : 1'h0;
    // code 0 gives the off pair; a pass through 0 is a toggle
    always @(posedge clock)
    begin
        highVoltageEnableN <= !cmd[0];
        lowVoltageEnable <= cmd[1];
    end
endmodule : pss_supervisor_model

`default_nettype wire
